// ===== rcf_defs.svh
// Constants for the reader command framer: bytes, fields, counts
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
// ------------------------------------------------------------
// Frame bytes and command codes
// ------------------------------------------------------------
`define RCF_START_BYTE    8'h01
`define RCF_CMD_READ      8'h48
`define RCF_CMD_CHECKED   8'h4c
`define RCF_CMD_PROGRAM   8'h6c
`define RCF_CMD_BURST2    5
`define RCF_CMD_FCHECK    2
// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define RCF_FIXED_BYTES   8'h03
`define RCF_CNT_SEL_READ  8'h04
`define RCF_CNT_SEL_PROG  8'h0e
`define RCF_SEL_BYTES     8'h03
`define RCF_PROG_BYTES    8'h08
`define RCF_CHKW_BYTES    8'h02
`define RCF_FN_READ       2'h0
`define RCF_FN_PROGRAM    2'h1
`define RCF_FN_LOCK       2'h2
`define RCF_FN_SEL_READ   2'h3
// ------------------------------------------------------------
// Burst timing and buffering
// ------------------------------------------------------------
`define RCF_BURST_UNIT_MS 1
`define RCF_FIFO_DEPTH    4
`endif

// ===== rcf_pkg.sv
// Types shared by the reader command framer modules
package rcf_pkg;
  typedef logic [7:0] rcf_byte_t;
  typedef enum logic [2:0] {
    rcf_hunt,
    rcf_len,
    rcf_body,
    rcf_check,
    rcf_hold
  } rcf_state_e;
endpackage

// ===== rcf_byte_if.sv
// Byte stream carrier between the input FIFO and the frame parser
`timescale 1ns/1ns
`default_nettype none
interface rcf_byte_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== rcf_fifo.sv
// Small valid/ready FIFO in front of the frame parser
`timescale 1ns/1ns
`default_nettype none
`include "rcf_defs.svh"
module rcf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RCF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  rcf_byte_if.src               out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers carry a wrap bit, so depth must be a power of two
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH != $bits(out_s.data)) begin
      $error("rcf_fifo: DEPTH must be a power of two >= 2 and WIDTH must match the carrier");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = in_valid && !full;
  wire              pop   = out_s.valid && out_s.ready;

  // Handshake outputs straight from the pointer compare
  assign in_ready    = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rd_r[AW-1:0]];

  // Storage needs no reset; only pointers define contents
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW + 1)'(push);
      rd_r <= rd_r + (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== rcf_framer.sv
// Reader command framer: checks host command frames and decodes their fields
//
// What this block does
// [R1] The length byte counts every frame byte after it except the closing block check byte.
// [R2] The last byte is a block check over all bytes but the start byte, recomputed and compared here.
// [R3] Command 48 is a plain single command, 4C adds a frame check, 6C adds that and a programming burst.
// [R4] The first data field is the charge-up burst length in milliseconds, 32 hex meaning 50 ms.
// [R5] With a second burst requested, the next field is the programming burst in ms, 0F meaning 15 ms.
// [R6] One count byte after the burst fields tells how many data fields follow.
// [R7] A general page read is command 48, one burst, count one and a write address such as 08.
// [R8] A page program frame carries eight data bytes low first, then a two-byte check word low first.
// [R9] A page lock uses command 6C, both bursts and one write address field such as 0A.
// [R10] Selective frames put a three-byte tag selection address, low first, right after the write address.
// [R11] A selective read uses command 4C, one burst, count four, write address then selection address.
// [R12] A selective program uses 6C, count fourteen, address, selection address, data and check word.
// [R13] The write address holds a six-bit page in its upper bits and a two-bit function code below.
// [R14] The block check is the exclusive-or of all bytes from the length through the last data field.
// [R15] A frame with a bad length or block check is dropped and input waits for the next start byte.
`timescale 1ns/1ns
`default_nettype none
`include "rcf_defs.svh"
module rcf_framer #(
  parameter int FIFO_DEPTH = `RCF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Serial byte input from the host link
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  // Decoded command, held until taken
  output logic             op_valid,
  input  wire logic        op_ready,
  output logic [7:0]       op_cmd,
  output logic             op_frame_check,
  output logic             op_has_burst2,
  output logic [7:0]       op_burst1_ms,
  output logic [7:0]       op_burst2_ms,
  output logic [7:0]       op_field_cnt,
  output logic [5:0]       op_page,
  output logic [1:0]       op_func,
  output logic             op_selective,
  output logic [23:0]      op_sel_addr,
  output logic [63:0]      op_prog_data,
  output logic [15:0]      op_check_word,
  // Frame error pulses
  output logic             err_len,
  output logic             err_check,
  output logic             err_cmd
);
  // ------------------------------------------------------------
  // Input buffer
  // ------------------------------------------------------------
  rcf_byte_if #(.WIDTH(8)) byte_s ();

  rcf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_valid (rx_valid),
    .in_ready (rx_ready),
    .in_data  (rx_data),
    .out_s    (byte_s)
  );

  // ------------------------------------------------------------
  // State and field registers
  // ------------------------------------------------------------
  rcf_pkg::rcf_state_e state_r;
  rcf_pkg::rcf_byte_t  len_r, idx_r, bcc_r, cmd_r, b1_r, b2_r, cnt_r, waddr_r;
  logic [23:0]         sel_r;
  logic [63:0]         prog_r;
  logic [15:0]         chkw_r;
  logic                len_err_r, bcc_err_r, cmd_err_r;

  // ------------------------------------------------------------
  // Byte position decode
  // ------------------------------------------------------------
  wire       [7:0] d        = byte_s.data;
  wire             take     = byte_s.valid && byte_s.ready;
  wire       [7:0] idx_nxt  = idx_r + 8'h01;
  wire             has2     = cmd_r[`RCF_CMD_BURST2];                          // [R3]
  wire       [7:0] cnt_idx  = has2 ? 8'h03 : 8'h02;                            // [R6]
  wire             sel      = (cnt_r == `RCF_CNT_SEL_READ) ||
                              (cnt_r == `RCF_CNT_SEL_PROG);                    // [R11] [R12]
  wire             after    = idx_r > cnt_idx;
  wire       [7:0] fld      = idx_r - cnt_idx - 8'h01;
  wire       [7:0] sel_pos  = fld - 8'h01;
  wire       [7:0] dpos     = fld - (sel ? 8'h04 : 8'h01);
  wire       [7:0] cpos     = dpos - `RCF_PROG_BYTES;
  wire             wa_hit   = after && (fld == 8'h00);
  wire             sel_hit  = after && sel && (sel_pos < `RCF_SEL_BYTES);      // [R10]
  wire             data_hit = after && (dpos < `RCF_PROG_BYTES);               // [R8]
  wire             chk_hit  = after && (cpos < `RCF_CHKW_BYTES);               // [R8]
  wire       [7:0] exp_len  = `RCF_FIXED_BYTES + {7'h00, has2} + cnt_r;        // [R1] [R7] [R9]
  wire             len_ok   = (len_r == exp_len) && (len_r > cnt_idx);
  wire             cmd_ok   = (cmd_r == `RCF_CMD_READ) || (cmd_r == `RCF_CMD_CHECKED) ||
                              (cmd_r == `RCF_CMD_PROGRAM);                     // [R3]
  wire             bcc_ok   = (d == bcc_r);                                    // [R2]
  wire             frame_ok = bcc_ok && len_ok && cmd_ok;
  wire             in_check = take && (state_r == rcf_pkg::rcf_check);

  // Parser stalls the FIFO while a decoded command waits
  assign byte_s.ready = (state_r != rcf_pkg::rcf_hold);

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= rcf_pkg::rcf_hunt;
    end else begin
      unique case (state_r)
        rcf_pkg::rcf_hunt: begin
          if (take && d == `RCF_START_BYTE) begin                              // [R15]
            state_r <= rcf_pkg::rcf_len;
          end
        end
        rcf_pkg::rcf_len: begin
          if (take) begin
            state_r <= (d == 8'h00) ? rcf_pkg::rcf_check : rcf_pkg::rcf_body;  // [R1]
          end
        end
        rcf_pkg::rcf_body: begin
          if (take && idx_nxt == len_r) begin                                  // [R1]
            state_r <= rcf_pkg::rcf_check;
          end
        end
        rcf_pkg::rcf_check: begin
          if (take) begin
            state_r <= frame_ok ? rcf_pkg::rcf_hold : rcf_pkg::rcf_hunt;       // [R15]
          end
        end
        rcf_pkg::rcf_hold: begin
          if (op_ready) begin
            state_r <= rcf_pkg::rcf_hunt;
          end
        end
      endcase
    end
  end

  // Length, position and running block check
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      len_r <= 8'h00;
      idx_r <= 8'h00;
      bcc_r <= 8'h00;
    end else if (take && state_r == rcf_pkg::rcf_len) begin
      len_r <= d;                                                              // [R1]
      idx_r <= 8'h00;
      bcc_r <= d;                                                              // [R14]
    end else if (take && state_r == rcf_pkg::rcf_body) begin
      idx_r <= idx_nxt;
      bcc_r <= bcc_r ^ d;                                                      // [R2] [R14]
    end
  end

  // Header fields; cleared per frame so a short frame cannot reuse old values
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_r <= 8'h00;
      b1_r  <= 8'h00;
      b2_r  <= 8'h00;
      cnt_r <= 8'h00;
    end else if (take && state_r == rcf_pkg::rcf_len) begin
      cmd_r <= 8'h00;
      b1_r  <= 8'h00;
      b2_r  <= 8'h00;
      cnt_r <= 8'h00;
    end else if (take && state_r == rcf_pkg::rcf_body) begin
      if (idx_r == 8'h00) cmd_r <= d;                                          // [R3]
      if (idx_r == 8'h01) b1_r <= d;                                           // [R4]
      if (idx_r == 8'h02 && has2) b2_r <= d;                                   // [R5]
      if (idx_r == cnt_idx) cnt_r <= d;                                        // [R6]
    end
  end

  // Payload fields, low byte first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waddr_r <= 8'h00;
      sel_r   <= 24'h000000;
      prog_r  <= 64'h0000000000000000;
      chkw_r  <= 16'h0000;
    end else if (take && state_r == rcf_pkg::rcf_body) begin
      if (wa_hit) waddr_r <= d;                                                // [R13]
      if (sel_hit) sel_r[{sel_pos[1:0], 3'b000} +: 8] <= d;                    // [R10]
      if (data_hit) prog_r[{dpos[2:0], 3'b000} +: 8] <= d;                     // [R8] [R12]
      if (chk_hit) chkw_r[{cpos[0], 3'b000} +: 8] <= d;                        // [R8]
    end
  end

  // Error pulses, one cycle each, on the closing byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      len_err_r <= 1'b0;
      bcc_err_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end else begin
      len_err_r <= in_check && !len_ok;                                        // [R15]
      bcc_err_r <= in_check && !bcc_ok;                                        // [R15]
      cmd_err_r <= in_check && !cmd_ok;                                        // [R3]
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Fields sit in flops that stay still while the command is held
  assign op_valid       = (state_r == rcf_pkg::rcf_hold);
  assign op_cmd         = cmd_r;
  assign op_frame_check = cmd_r[`RCF_CMD_FCHECK];
  assign op_has_burst2  = has2;
  assign op_burst1_ms   = b1_r;
  assign op_burst2_ms   = b2_r;
  assign op_field_cnt   = cnt_r;
  assign op_page        = waddr_r[7:2];                                        // [R13]
  assign op_func        = waddr_r[1:0];                                        // [R13]
  assign op_selective   = sel;
  assign op_sel_addr    = sel_r;
  assign op_prog_data   = prog_r;
  assign op_check_word  = chkw_r;
  assign err_len        = len_err_r;
  assign err_check      = bcc_err_r;
  assign err_cmd        = cmd_err_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Framing: start byte, length and running block check
  hunt_discard_a: assert property (state_r == rcf_pkg::rcf_hunt && take && d != `RCF_START_BYTE  // [R15]
    |=> state_r == rcf_pkg::rcf_hunt)
    else $error("non-start byte left hunt");
  len_capture_a: assert property (state_r == rcf_pkg::rcf_len && take && d != 8'h00  // [R1]
    |=> len_r == $past(d) && state_r == rcf_pkg::rcf_body)
    else $error("length not taken");
  body_end_a: assert property (state_r == rcf_pkg::rcf_body && take && idx_nxt == len_r  // [R1]
    |=> state_r == rcf_pkg::rcf_check)
    else $error("length count not honoured");
  bcc_fold_a: assert property (state_r == rcf_pkg::rcf_body && take  // [R14]
    |=> bcc_r == ($past(bcc_r) ^ $past(d)))
    else $error("block check fold wrong");

  // Field capture; multi-byte fields land low byte first
  cmd_field_a: assert property (state_r == rcf_pkg::rcf_body && take && idx_r == 8'h00  // [R3]
    |=> op_cmd == $past(d))
    else $error("command byte not stored");
  burst_field_a: assert property (state_r == rcf_pkg::rcf_body && take && idx_r == 8'h01  // [R4]
    |=> op_burst1_ms == $past(d))
    else $error("charge-up burst not stored");
  burst2_field_a: assert property (state_r == rcf_pkg::rcf_body && take && idx_r == 8'h02 && has2  // [R5]
    |=> op_burst2_ms == $past(d))
    else $error("programming burst not stored");
  count_field_a: assert property (state_r == rcf_pkg::rcf_body && take && idx_r == cnt_idx  // [R6]
    |=> op_field_cnt == $past(d))
    else $error("field count not stored");
  waddr_split_a: assert property (state_r == rcf_pkg::rcf_body && take && wa_hit  // [R13]
    |=> op_page == $past(d[7:2]) && op_func == $past(d[1:0]))
    else $error("write address split wrong");
  sel_low_a: assert property (state_r == rcf_pkg::rcf_body && take && sel_hit && sel_pos == 8'h00  // [R10]
    |=> op_sel_addr[7:0] == $past(d))
    else $error("selection address not low first");
  sel_top_a: assert property (state_r == rcf_pkg::rcf_body && take && sel_hit && sel_pos == 8'h02  // [R10]
    |=> op_sel_addr[23:16] == $past(d))
    else $error("selection address top byte wrong");
  data_low_a: assert property (state_r == rcf_pkg::rcf_body && take && data_hit && dpos == 8'h00  // [R8]
    |=> op_prog_data[7:0] == $past(d))
    else $error("program data not low first");
  chkw_low_a: assert property (state_r == rcf_pkg::rcf_body && take && chk_hit && cpos == 8'h00  // [R8]
    |=> op_check_word[7:0] == $past(d))
    else $error("check word not low first");

  // Closing byte: accept and hold, or drop with a one-cycle pulse on each failed check
  accept_ok_a: assert property (in_check && frame_ok  // [R2]
    |=> op_valid && !err_len && !err_check)
    else $error("good frame not accepted");
  bad_check_a: assert property (in_check && !bcc_ok  // [R15]
    |=> err_check && !op_valid ##1 !err_check)
    else $error("bad check not dropped");
  bad_len_a: assert property (in_check && len_r != exp_len  // [R1]
    |=> err_len && state_r == rcf_pkg::rcf_hunt)
    else $error("bad length not dropped");
  bad_cmd_a: assert property (in_check && !cmd_ok  // [R3]
    |=> err_cmd && !op_valid)
    else $error("unknown command not dropped");
  cmd_legal_a: assert property (op_valid  // [R3]
    |-> cmd_ok && (op_has_burst2 == (op_cmd == `RCF_CMD_PROGRAM)))
    else $error("illegal command accepted");
  hold_stall_a: assert property (op_valid && !op_ready  // [R8]
    |=> op_valid && !byte_s.ready && $stable(op_prog_data))
    else $error("held command moved");

  // Main scenarios; the stall shows back-pressure reaching the host link
  read_frame_c: cover property (op_valid && op_cmd == `RCF_CMD_READ && op_field_cnt == 8'h01);
  sel_prog_c: cover property (op_valid && op_selective && op_func == `RCF_FN_PROGRAM);
  bad_check_c: cover property (err_check);
  empty_frame_c: cover property (err_len && err_cmd);
  stall_c: cover property (op_valid && !op_ready ##1 !rx_ready);
endmodule
`default_nettype wire

// ===== rcf_host_model.sv
// Host side model: sends command frames byte by byte into the framer
`timescale 1ns/1ns
`default_nettype none
`include "rcf_defs.svh"
module rcf_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Byte link toward the framer
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data
);
  // Idle link at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // Frame sender; mode 1 spoils the check byte, mode 2 shortens the length
  task automatic send(input rcf_pkg::rcf_byte_t body[$], input int mode);
    rcf_pkg::rcf_byte_t frm[$];
    rcf_pkg::rcf_byte_t bcc;
    frm = body;
    frm.push_front(8'(body.size() - (mode == 2)));
    bcc = 8'h00;
    foreach (frm[i]) bcc ^= frm[i];
    frm.push_back((mode == 1) ? ~bcc : bcc);
    frm.push_front(`RCF_START_BYTE);
    foreach (frm[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= frm[i];
      // Held until an edge sees the FIFO willing
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~frm[frm.size() - 1];  // Released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the reader command framer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        ref_clk, rst, rx_valid, rx_ready, op_valid, op_ready;
  logic        op_frame_check, op_has_burst2, op_selective, err_len, err_check, err_cmd;
  logic [7:0]  rx_data, op_cmd, op_burst1_ms, op_burst2_ms, op_field_cnt;
  logic [5:0]  op_page;
  logic [1:0]  op_func;
  logic [23:0] op_sel_addr;
  logic [63:0] op_prog_data;
  logic [15:0] op_check_word;
  int          miscompares, check_count;

  rcf_host_model u_rcf_host_model (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
                                   .rx_data(rx_data));
  rcf_framer u_rcf_framer (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .op_valid(op_valid), .op_ready(op_ready), .op_cmd(op_cmd),
    .op_frame_check(op_frame_check), .op_has_burst2(op_has_burst2), .op_burst1_ms(op_burst1_ms),
    .op_burst2_ms(op_burst2_ms), .op_field_cnt(op_field_cnt), .op_page(op_page), .op_func(op_func),
    .op_selective(op_selective), .op_sel_addr(op_sel_addr), .op_prog_data(op_prog_data),
    .op_check_word(op_check_word), .err_len(err_len), .err_check(err_check), .err_cmd(err_cmd));

  // 20 MHz clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a decoded command
  task automatic wait_op();
    int n;
    n = 0;
    while (op_valid !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    chk(64'(op_valid), 64'h1);
  endtask
  // Hand the command to the consumer; it must then drop
  task automatic take_op();
    op_ready <= 1'b1;
    @(posedge ref_clk);
    op_ready <= 1'b0;
    @(posedge ref_clk);
    chk(64'(op_valid), 64'h0);
  endtask
  // Header fields, expectations built from command, count and address
  task automatic chk_hdr(input logic [7:0] cmd, input logic [7:0] b2, input logic [7:0] cnt, input logic [7:0] wa);
    chk({op_cmd, op_frame_check, op_has_burst2, op_burst1_ms, op_burst2_ms, op_field_cnt, op_page, op_func,
         op_selective}, {cmd, cmd != 8'h48, cmd == 8'h6c, 8'h32, b2, cnt, wa, cnt == 8'h04 || cnt == 8'h0e});
  endtask
  // Collects what shows up in the cycles after a bad frame
  task automatic watch(output logic [3:0] seen);
    seen = 4'h0;
    repeat (12) begin
      @(posedge ref_clk);
      seen |= {op_valid, err_len, err_check, err_cmd};
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_read();
    u_rcf_host_model.send('{8'h48, 8'h32, 8'h01, 8'h08}, 0);
    wait_op();
    chk_hdr(8'h48, 8'h00, 8'h01, 8'h08);
    take_op();
  endtask
  task automatic t_program();
    u_rcf_host_model.send('{8'h6c, 8'h32, 8'h0f, 8'h0b, 8'h09, 8'h47, 8'hc6, 8'h2d, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h96, 8'h50}, 0);
    wait_op();
    chk_hdr(8'h6c, 8'h0f, 8'h0b, 8'h09);
    chk(op_prog_data, 64'h2dc647);
    chk(64'(op_check_word), 64'h5096);
    take_op();
  endtask
  task automatic t_lock();
    u_rcf_host_model.send('{8'h6c, 8'h32, 8'h07, 8'h01, 8'h0a}, 0);
    wait_op();
    chk_hdr(8'h6c, 8'h07, 8'h01, 8'h0a);
    take_op();
  endtask
  task automatic t_sel_prog();
    u_rcf_host_model.send('{8'h6c, 8'h32, 8'h0f, 8'h0e, 8'h09, 8'h56, 8'h34, 8'h12, 8'h11, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h9f, 8'hbd}, 0);
    wait_op();
    chk_hdr(8'h6c, 8'h0f, 8'h0e, 8'h09);
    chk(64'(op_sel_addr), 64'h123456);
    chk(op_prog_data, 64'h11);
    chk(64'(op_check_word), 64'hbd9f);
    take_op();
  endtask
  // Bad frames: spoiled check, short length, unknown command, empty body
  task automatic t_bad();
    logic [3:0]         seen;
    rcf_pkg::rcf_byte_t none[$];
    u_rcf_host_model.send('{8'h48, 8'h32, 8'h01, 8'h08}, 1);
    watch(seen);
    chk(64'(seen), 64'h2);
    u_rcf_host_model.send('{8'h48, 8'h32, 8'h01, 8'h08}, 2);
    watch(seen);
    chk(64'(seen[3:2]), 64'h1);
    u_rcf_host_model.send('{8'h47, 8'h32, 8'h01, 8'h08}, 0);
    watch(seen);
    chk(64'(seen), 64'h1);
    // Length zero jumps straight to the check byte and fails length and command
    u_rcf_host_model.send(none, 0);
    watch(seen);
    chk(64'(seen), 64'h5);
  endtask
  // Consumer stalls: FIFO fills and refuses, then drains to empty
  task automatic t_stall();
    logic fell;
    fell = 1'b0;
    u_rcf_host_model.send('{8'h48, 8'h32, 8'h01, 8'h08}, 0);
    wait_op();
    fork
      u_rcf_host_model.send('{8'h4c, 8'h32, 8'h04, 8'h0b, 8'h56, 8'h34, 8'h12}, 0);
      begin
        repeat (30) begin
          @(posedge ref_clk);
          if (rx_ready === 1'b0) fell = 1'b1;
        end
        chk(64'(fell), 64'h1);
        chk_hdr(8'h48, 8'h00, 8'h01, 8'h08);
        take_op();
      end
    join
    wait_op();
    chk_hdr(8'h4c, 8'h00, 8'h04, 8'h0b);
    chk(64'(op_sel_addr), 64'h123456);
    take_op();
    chk(64'(rx_ready), 64'h1);
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence; bad frames come before good ones to prove recovery
  initial begin
    rst = 1'b1;
    op_ready = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({rx_ready, op_valid, err_len, err_check, err_cmd}, 64'h10);
    t_bad();
    t_read();
    t_program();
    t_lock();
    t_sel_prog();
    t_stall();
    report_and_stop();
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #(20000 * 50);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
